/* pmev_regs.sv */
// Power-management event register bank: status, enables, sleep control
// Functional notes
// RQ1: Wake flag set on enabled event while asleep
// RQ2: Alarm flag set only waking with alarm
// RQ3: Sleep button flag needs pin mapping first
// RQ4: Power button flag needs pin mapping first
// RQ5: Enabled global-lock write-one raises control interrupt
// RQ6: Bus-master status and reload have no behaviour
// RQ7: Timer flag set on timer bit 23 toggle
// RQ8: Status bits sticky, write one clears
// RQ9: Alarm/button enables raise interrupt on flag
// RQ10: Timer enable raises interrupt on toggle
// RQ11: Sleep trigger write-only, enters chosen sleep type
// RQ12: Sleep type decode, three codes reserved
// RQ13: Lock release write raises management interrupt event
// RQ14: Interrupt select routes events, set by commands
// RQ15: Setup index reads back last write
// RQ16: Undefined setup index writes are ignored
// RQ17: General status set by mapped event, W1C
// RQ18: Lid bit set on any lid change
// RQ19: General enables gate status onto interrupt
// RQ20: Boot software maps lid pin to bit 6
// RQ21: All registers reset to zero
// RQ22: Software uses defined widths and alignment
// RQ23: Block sits at relocatable I/O base AC00h
// RQ24: Interrupt is OR of enabled status flags
`timescale 1ns/1ps
module pmev_regs #(
   parameter logic [15:0] BASE_ADDR = pmev_pkg::BASE_DEFAULT, // RQ23
   parameter int          GPIO_N    = pmev_pkg::GPIO_N
) (
   input  wire logic                       clock_in,
   input  wire logic                       rst_in,
   input  wire pmev_pkg::pmev_io_req_t     io_req_in,
   output logic      [pmev_pkg::IO_DW-1:0] io_rdata_out,
   output logic                            io_ack_out,
   input  wire logic [GPIO_N-1:0]          gpio_in,
   input  wire logic                       alarm_interrupt_line_in,
   input  wire logic                       pm_timer_msb_in,
   input  wire logic                       global_lock_set_in,
   input  wire logic                       acpi_enable_cmd_in,
   input  wire logic                       acpi_disable_cmd_in,
   output logic                            sci_out,
   output logic                            smi_out,
   output logic                            smi_event_out,
   output logic                            sleep_request_out,
   output logic      [2:0]                 sleep_type_out,
   output logic                            wake_out,
   output pmev_pkg::pmev_power_t           power_state_out
);
   localparam int MAP_W = pmev_pkg::MAP_W;

   // Block-relative offset of an access, or all ones when outside
   function automatic logic [7:0] rel_offset(input logic [15:0] addr);
      logic [15:0] diff;
      diff = addr - BASE_ADDR;
      if (addr >= BASE_ADDR && diff < {8'h00, pmev_pkg::BLOCK_SPAN}) begin
         rel_offset = diff[7:0];
      end else begin
         rel_offset = 8'hFF;
      end
   endfunction

   function automatic logic idx_is_pin(input logic [15:0] idx);
      idx_is_pin = idx >= pmev_pkg::IDX_PIN_FIRST &&
                   idx <= pmev_pkg::IDX_PIN_LAST;
   endfunction

   function automatic logic reserved_type(input logic [2:0] t);
      reserved_type = !(t == pmev_pkg::SLP_S0 || t == pmev_pkg::SLP_S1 ||
                        t == pmev_pkg::SLP_S2 || t == pmev_pkg::SLP_S4 ||
                        t == pmev_pkg::SLP_S5);
   endfunction

   logic [15:0]                 evt_status_reg;
   logic [15:0]                 evt_status_next;
   logic [15:0]                 evt_enable_reg;
   logic [2:0]                  sleep_type_reg;
   logic                        int_select_reg;
   logic [15:0]                 setup_index_reg;
   logic [15:0]                 gp_status_reg;
   logic [15:0]                 gp_status_next;
   logic [15:0]                 gp_enable_reg;
   logic                        lock_sci_reg;
   pmev_pkg::pmev_power_t       power_reg;

   logic [GPIO_N-1:0]           gpio_s1_reg;
   logic [GPIO_N-1:0]           gpio_s2_reg;
   logic [GPIO_N-1:0]           gpio_s3_reg;
   logic [1:0]                  pin_s1_reg;
   logic [1:0]                  pin_s2_reg;
   logic                        timer_s3_reg;

   logic [7:0]                  offset;
   logic                        wr_hit;
   logic [15:0]                 wdata;
   logic                        alarm_sync;
   logic                        timer_toggle;
   logic [GPIO_N-1:0]           gpio_change;
   logic [GPIO_N-1:0]           gpio_rise;
   logic                        pwr_press;
   logic                        slp_press;
   logic [15:0]                 gp_set;
   logic [15:0]                 evt_set;
   logic                        asleep;
   logic                        wake_now;
   logic                        any_event;
   logic                        trigger_sleep;
   logic [MAP_W-1:0]            map_rd_data;
   logic [GPIO_N*MAP_W-1:0]     map_entries;
   logic [15:0]                 rdata_next;

   assign offset = rel_offset(io_req_in.addr);
   assign wr_hit = io_req_in.wr;
   assign wdata  = io_req_in.wdata;

   // Pin synchronisers; stage one feeds only stage two
   always_ff @(posedge clock_in) begin
      if (rst_in) begin
         gpio_s1_reg  <= '0;
         gpio_s2_reg  <= '0;
         gpio_s3_reg  <= '0;
         pin_s1_reg   <= '0;
         pin_s2_reg   <= '0;
         timer_s3_reg <= 1'b0;
      end else begin
         gpio_s1_reg  <= gpio_in;
         gpio_s2_reg  <= gpio_s1_reg;
         gpio_s3_reg  <= gpio_s2_reg;
         pin_s1_reg   <= {alarm_interrupt_line_in, pm_timer_msb_in};
         pin_s2_reg   <= pin_s1_reg;
         timer_s3_reg <= pin_s2_reg[0];
      end
   end

   assign alarm_sync   = pin_s2_reg[1];
   assign timer_toggle = pin_s2_reg[0] ^ timer_s3_reg; // RQ7
   assign gpio_change  = gpio_s2_reg ^ gpio_s3_reg;
   assign gpio_rise    = gpio_s2_reg & ~gpio_s3_reg;

   // Pin-to-bit map, written through the setup index and data pair
   pmev_map_table #(
      .DEPTH (GPIO_N),
      .WIDTH (MAP_W)
   ) u_map (
      .clock_in    (clock_in),
      .rst_in      (rst_in),
      .wr_en_in    (wr_hit && offset == pmev_pkg::OFS_SETUP_DATA &&
                    idx_is_pin(setup_index_reg)),
      .wr_addr_in  (setup_index_reg[$clog2(GPIO_N)-1:0]),
      .wr_data_in  (wdata[MAP_W-1:0]),
      .rd_addr_in  (setup_index_reg[$clog2(GPIO_N)-1:0]),
      .rd_data_out (map_rd_data),
      .entries_out (map_entries)
   );

   // Buttons count only once a pin is assigned; general bits on any change
   always_comb begin
      logic [MAP_W-1:0] ent;
      ent       = '0;
      pwr_press = 1'b0;
      slp_press = 1'b0;
      gp_set    = '0;
      for (int p = 0; p < GPIO_N; p++) begin
         ent = map_entries[p*MAP_W +: MAP_W];
         if (ent == pmev_pkg::MAP_PWR_BTN && gpio_rise[p]) begin
            pwr_press = 1'b1; // RQ4
         end
         if (ent == pmev_pkg::MAP_SLP_BTN && gpio_rise[p]) begin
            slp_press = 1'b1; // RQ3
         end
         if (ent[pmev_pkg::MAP_GP_FLAG] && gpio_change[p]) begin
            gp_set[ent[3:0]] = 1'b1; // RQ17 RQ18
         end
      end
   end

   assign asleep = power_reg != pmev_pkg::PMEV_STATE_ON;

   always_comb begin
      evt_set = '0;
      evt_set[pmev_pkg::BIT_ALARM]   = asleep && alarm_sync; // RQ2
      evt_set[pmev_pkg::BIT_SLP_BTN] = slp_press;
      evt_set[pmev_pkg::BIT_PWR_BTN] = pwr_press;
      evt_set[pmev_pkg::BIT_GLOCK]   = global_lock_set_in;
      evt_set[pmev_pkg::BIT_TIMER]   = timer_toggle;
   end

   // Wake on any enabled event source while asleep
   assign wake_now = asleep &&
      (|(evt_set & evt_enable_reg & pmev_pkg::EVT_EN_MASK) ||
       |(gp_set & gp_enable_reg)); // RQ1

   // Set wins over a write-one clear in the same cycle
   always_comb begin
      evt_status_next = evt_status_reg;
      if (wr_hit && offset == pmev_pkg::OFS_EVT_STATUS) begin
         evt_status_next = evt_status_next & ~wdata; // RQ8
      end
      evt_status_next = evt_status_next | evt_set; // RQ7
      if (wake_now) begin
         evt_status_next[pmev_pkg::BIT_WAKE] = 1'b1; // RQ1
      end
      evt_status_next = evt_status_next & pmev_pkg::EVT_STS_MASK
                        & ~(16'h0001 << pmev_pkg::BIT_BUS_MASTER); // RQ6
   end

   always_comb begin
      gp_status_next = gp_status_reg;
      if (wr_hit && offset == pmev_pkg::OFS_GP_STATUS) begin
         gp_status_next = gp_status_next & ~wdata; // RQ17
      end
      gp_status_next = gp_status_next | gp_set;
   end

   always_ff @(posedge clock_in) begin
      if (rst_in) begin
         evt_status_reg <= pmev_pkg::REG_RESET; // RQ21
         gp_status_reg  <= pmev_pkg::REG_RESET;
      end else begin
         evt_status_reg <= evt_status_next;
         gp_status_reg  <= gp_status_next;
      end
   end

   // Enables and setup index
   always_ff @(posedge clock_in) begin
      if (rst_in) begin
         evt_enable_reg <= pmev_pkg::REG_RESET; // RQ21
         gp_enable_reg  <= pmev_pkg::REG_RESET;
         setup_index_reg  <= pmev_pkg::REG_RESET;
      end else if (wr_hit) begin
         if (offset == pmev_pkg::OFS_EVT_ENABLE) begin
            evt_enable_reg <= wdata & pmev_pkg::EVT_EN_MASK;
         end
         if (offset == pmev_pkg::OFS_GP_ENABLE) begin
            gp_enable_reg <= wdata; // RQ19
         end
         if (offset == pmev_pkg::OFS_SETUP_INDEX && idx_is_pin(wdata)) begin
            setup_index_reg <= wdata; // RQ15 RQ16
         end
      end
   end

   // A reserved sleep type is stored but never entered
   assign trigger_sleep = wr_hit && offset == pmev_pkg::OFS_SLEEP_CTRL &&
                          wdata[pmev_pkg::BIT_SLP_TRIG] &&
                          !reserved_type(wdata[pmev_pkg::SLP_TYPE_LSB +: 3]);

   always_ff @(posedge clock_in) begin
      if (rst_in) begin
         sleep_type_reg <= pmev_pkg::SLP_S0; // RQ21
      end else if (wr_hit && offset == pmev_pkg::OFS_SLEEP_CTRL) begin
         sleep_type_reg <= wdata[pmev_pkg::SLP_TYPE_LSB +: 3];
      end
   end

   // Select bit follows the enable and disable commands only
   always_ff @(posedge clock_in) begin
      if (rst_in) begin
         int_select_reg <= 1'b0;
      end else if (acpi_enable_cmd_in) begin
         int_select_reg <= 1'b1; // RQ14
      end else if (acpi_disable_cmd_in) begin
         int_select_reg <= 1'b0; // RQ14
      end
   end

   always_ff @(posedge clock_in) begin
      if (rst_in) begin
         power_reg <= pmev_pkg::PMEV_STATE_ON;
      end else if (trigger_sleep) begin
         unique case (wdata[pmev_pkg::SLP_TYPE_LSB +: 3]) // RQ11 RQ12
            pmev_pkg::SLP_S1: power_reg <= pmev_pkg::PMEV_STATE_S1;
            pmev_pkg::SLP_S2: power_reg <= pmev_pkg::PMEV_STATE_S2;
            pmev_pkg::SLP_S4: power_reg <= pmev_pkg::PMEV_STATE_S4;
            pmev_pkg::SLP_S5: power_reg <= pmev_pkg::PMEV_STATE_S5;
            default:          power_reg <= pmev_pkg::PMEV_STATE_ON;
         endcase
      end else if (wake_now) begin
         power_reg <= pmev_pkg::PMEV_STATE_ON;
      end
   end

   // Lock write-one pulse kept apart from the sticky flag it clears
   always_ff @(posedge clock_in) begin
      if (rst_in) begin
         lock_sci_reg <= 1'b0;
      end else begin
         lock_sci_reg <= wr_hit && offset == pmev_pkg::OFS_EVT_STATUS &&
                         wdata[pmev_pkg::BIT_GLOCK] &&
                         evt_enable_reg[pmev_pkg::BIT_GLOCK]; // RQ5
      end
   end

   // Wake bit has no enable; it follows the event that caused it
   assign any_event =
      |(evt_status_next & evt_enable_reg & pmev_pkg::EVT_EN_MASK) ||
      |(gp_status_next & gp_enable_reg) || lock_sci_reg; // RQ9 RQ10 RQ24

   always_ff @(posedge clock_in) begin
      if (rst_in) begin
         sci_out <= 1'b0;
         smi_out <= 1'b0;
      end else begin
         sci_out <= any_event && int_select_reg; // RQ14 RQ24
         smi_out <= any_event && !int_select_reg; // RQ14
      end
   end

   always_ff @(posedge clock_in) begin
      if (rst_in) begin
         smi_event_out     <= 1'b0;
         sleep_request_out <= 1'b0;
         sleep_type_out    <= pmev_pkg::SLP_S0;
         wake_out          <= 1'b0;
         power_state_out   <= pmev_pkg::PMEV_STATE_ON;
      end else begin
         smi_event_out     <= wr_hit &&
                              offset == pmev_pkg::OFS_SLEEP_CTRL &&
                              wdata[pmev_pkg::BIT_GLOCK_REL]; // RQ13
         sleep_request_out <= trigger_sleep; // RQ11
         sleep_type_out    <= trigger_sleep ?
                              wdata[pmev_pkg::SLP_TYPE_LSB +: 3] :
                              sleep_type_out;
         wake_out          <= wake_now && !trigger_sleep;
         power_state_out   <= power_reg;
      end
   end

   // Read mux; trigger, release and reload bits always read zero
   always_comb begin
      rdata_next = '0;
      unique case (offset)
         pmev_pkg::OFS_EVT_STATUS: rdata_next = evt_status_reg;
         pmev_pkg::OFS_EVT_ENABLE: rdata_next = evt_enable_reg;
         pmev_pkg::OFS_SLEEP_CTRL: rdata_next = pmev_pkg::SLP_CTRL_RMASK &
            {3'h0, sleep_type_reg, 9'h000, int_select_reg}; // RQ11 RQ6
         pmev_pkg::OFS_SETUP_INDEX:  rdata_next = setup_index_reg; // RQ15
         pmev_pkg::OFS_GP_STATUS:  rdata_next = gp_status_reg;
         pmev_pkg::OFS_GP_ENABLE:  rdata_next = gp_enable_reg;
         pmev_pkg::OFS_SETUP_DATA: rdata_next = {8'h00, map_rd_data};
         default:                  rdata_next = '0;
      endcase
   end

   always_ff @(posedge clock_in) begin
      if (rst_in) begin
         io_rdata_out <= '0;
         io_ack_out   <= 1'b0;
      end else begin
         io_rdata_out <= io_req_in.rd ? rdata_next : '0;
         io_ack_out   <= io_req_in.rd || io_req_in.wr;
      end
   end
endmodule

/* pmev_pkg.sv */
// Constants and types shared by the power-management event register bank
package pmev_pkg;
   localparam int          IO_AW          = 16;
   localparam int          IO_DW          = 16;
   localparam int          GPIO_N         = 8;
   localparam int          MAP_W          = 8;
   localparam logic [15:0] BASE_DEFAULT   = 16'hAC00;
   // Register offsets within the block
   localparam logic [7:0]  OFS_EVT_STATUS = 8'h08;
   localparam logic [7:0]  OFS_EVT_ENABLE = 8'h0A;
   localparam logic [7:0]  OFS_SLEEP_CTRL = 8'h0C;
   localparam logic [7:0]  OFS_SETUP_INDEX  = 8'h0E;
   localparam logic [7:0]  OFS_GP_STATUS  = 8'h10;
   localparam logic [7:0]  OFS_GP_ENABLE  = 8'h12;
   localparam logic [7:0]  OFS_SETUP_DATA = 8'h14;
   localparam logic [7:0]  BLOCK_SPAN     = 8'h16;
   localparam logic [15:0] REG_RESET      = 16'h0000;
   // Event status / enable bit positions
   localparam int          BIT_WAKE       = 15;
   localparam int          BIT_ALARM      = 10;
   localparam int          BIT_SLP_BTN    = 9;
   localparam int          BIT_PWR_BTN    = 8;
   localparam int          BIT_GLOCK      = 5;
   localparam int          BIT_BUS_MASTER = 4;
   localparam int          BIT_TIMER      = 0;
   localparam logic [15:0] EVT_STS_MASK   = 16'h8731;
   localparam logic [15:0] EVT_EN_MASK    = 16'h0721;
   // Sleep control fields
   localparam int          BIT_SLP_TRIG   = 13;
   localparam int          SLP_TYPE_LSB   = 10;
   localparam int          BIT_GLOCK_REL  = 2;
   localparam int          BIT_BM_RELOAD  = 1;
   localparam int          BIT_INT_SEL    = 0;
   localparam logic [15:0] SLP_CTRL_RMASK = 16'h1C01;
   localparam logic [2:0]  SLP_S0         = 3'h0;
   localparam logic [2:0]  SLP_S1         = 3'h1;
   localparam logic [2:0]  SLP_S2         = 3'h2;
   localparam logic [2:0]  SLP_S4         = 3'h4;
   localparam logic [2:0]  SLP_S5         = 3'h5;
   // Setup index range that assigns a pin to a status bit
   localparam logic [15:0] IDX_PIN_FIRST  = 16'h0010;
   localparam logic [15:0] IDX_PIN_LAST   = 16'h0017;
   // Pin map entry codes
   localparam logic [7:0]  MAP_NONE       = 8'h00;
   localparam logic [7:0]  MAP_PWR_BTN    = 8'h01;
   localparam logic [7:0]  MAP_SLP_BTN    = 8'h02;
   localparam int          MAP_GP_FLAG    = 7;
   localparam int          LID_GP_BIT     = 6;

   typedef enum logic [2:0] {
      PMEV_STATE_ON,
      PMEV_STATE_S1,
      PMEV_STATE_S2,
      PMEV_STATE_S4,
      PMEV_STATE_S5
   } pmev_power_t;

   typedef struct packed {
      logic [IO_AW-1:0] addr;
      logic             wr;
      logic             rd;
      logic [IO_DW-1:0] wdata;
   } pmev_io_req_t;
endpackage

/* pmev_map_table.sv */
// Pin-to-status-bit map table with registered read data
`timescale 1ns/1ps
module pmev_map_table #(
   parameter int DEPTH = 8,
   parameter int WIDTH = 8
) (
   input  wire logic                     clock_in,
   input  wire logic                     rst_in,
   input  wire logic                     wr_en_in,
   input  wire logic [$clog2(DEPTH)-1:0] wr_addr_in,
   input  wire logic [WIDTH-1:0]         wr_data_in,
   input  wire logic [$clog2(DEPTH)-1:0] rd_addr_in,
   output logic      [WIDTH-1:0]         rd_data_out,
   output logic      [DEPTH*WIDTH-1:0]   entries_out
);
   logic [WIDTH-1:0] mem_reg [DEPTH];

   always_ff @(posedge clock_in) begin
      if (rst_in) begin
         for (int i = 0; i < DEPTH; i++) begin
            mem_reg[i] <= '0;
         end
      end else if (wr_en_in) begin
         mem_reg[wr_addr_in] <= wr_data_in;
      end
   end

   always_ff @(posedge clock_in) begin
      if (rst_in) begin
         rd_data_out <= '0;
      end else begin
         rd_data_out <= mem_reg[rd_addr_in];
      end
   end

   // Flat copy so every pin decodes its own target in parallel
   always_ff @(posedge clock_in) begin
      if (rst_in) begin
         entries_out <= '0;
      end else begin
         for (int i = 0; i < DEPTH; i++) begin
            entries_out[i*WIDTH +: WIDTH] <= mem_reg[i];
         end
      end
   end
endmodule

/* pmev_regs_props.sv */
// Concurrent checks on the ports of the power-management event registers
`timescale 1ns/1ps
module pmev_regs_props #(
   parameter logic [15:0] BASE_ADDR = pmev_pkg::BASE_DEFAULT,
   parameter int          GPIO_N    = pmev_pkg::GPIO_N
) (
   input wire logic                       clock_in,
   input wire logic                       rst_in,
   input wire pmev_pkg::pmev_io_req_t     io_req_in,
   input wire logic [pmev_pkg::IO_DW-1:0] io_rdata_out,
   input wire logic                       io_ack_out,
   input wire logic [GPIO_N-1:0]          gpio_in,
   input wire logic                       alarm_interrupt_line_in,
   input wire logic                       pm_timer_msb_in,
   input wire logic                       global_lock_set_in,
   input wire logic                       acpi_enable_cmd_in,
   input wire logic                       acpi_disable_cmd_in,
   input wire logic                       sci_out,
   input wire logic                       smi_out,
   input wire logic                       smi_event_out,
   input wire logic                       sleep_request_out,
   input wire logic [2:0]                 sleep_type_out,
   input wire logic                       wake_out,
   input wire pmev_pkg::pmev_power_t      power_state_out
);
   logic ctrl_hit;
   assign ctrl_hit = io_req_in.wr && (io_req_in.addr ==
                     BASE_ADDR + {8'h00, pmev_pkg::OFS_SLEEP_CTRL});

   default clocking cb @(posedge clock_in);
   endclocking
   default disable iff (rst_in);

   sequence trig_ok_s;
      ctrl_hit && io_req_in.wdata[13] &&
      (io_req_in.wdata[12:10] inside {3'h0, 3'h1, 3'h2, 3'h4, 3'h5});
   endsequence
   sequence trig_bad_s;
      ctrl_hit && io_req_in.wdata[13] &&
      (io_req_in.wdata[12:10] inside {3'h3, 3'h6, 3'h7});
   endsequence
   sequence lock_rel_s;
      ctrl_hit && io_req_in.wdata[2];
   endsequence

   ack_follows_a: assert property (
      (io_req_in.wr || io_req_in.rd) |=> io_ack_out)
      else $error("request without acknowledge");
   ack_idle_a: assert property (
      !(io_req_in.wr || io_req_in.rd) |=> !io_ack_out)
      else $error("acknowledge without request");
   rdata_idle_a: assert property (
      !io_req_in.rd |=> io_rdata_out == 16'h0000)
      else $error("read data outside a read");
   sleep_go_a: assert property (
      trig_ok_s |=> sleep_request_out &&
      sleep_type_out == $past(io_req_in.wdata[12:10]))
      else $error("sleep trigger not honoured");
   sleep_refused_a: assert property (
      trig_bad_s |=> !sleep_request_out)
      else $error("reserved sleep type accepted");
   sleep_pulse_a: assert property (
      sleep_request_out |=> !sleep_request_out)
      else $error("sleep request longer than one cycle");
   state_off_a: assert property (
      sleep_request_out && sleep_type_out == pmev_pkg::SLP_S5
      |=> power_state_out == pmev_pkg::PMEV_STATE_S5)
      else $error("soft off not entered");
   lock_release_a: assert property (
      lock_rel_s |=> smi_event_out)
      else $error("lock release gave no event");
   lock_cause_a: assert property (
      !(ctrl_hit && io_req_in.wdata[2]) |=> !smi_event_out)
      else $error("management event without release write");
   route_excl_a: assert property (
      !(sci_out && smi_out))
      else $error("both interrupt routes active");
   wake_pulse_a: assert property (
      wake_out |=> !wake_out && power_state_out == pmev_pkg::PMEV_STATE_ON)
      else $error("wake pulse or state wrong");
endmodule

bind pmev_regs pmev_regs_props #(.BASE_ADDR(BASE_ADDR), .GPIO_N(GPIO_N))
   props (.*);

/* pmev_regs_bench.sv */
// Self-checking bench for the power-management event register bank
`timescale 1ns/1ps
module pmev_regs_bench;
   logic                   clock_in = 1'b0;
   logic                   rst_in = 1'b1;
   pmev_pkg::pmev_io_req_t io_req_in = '0;
   logic [15:0]            io_rdata_out;
   logic                   io_ack_out;
   logic [7:0]             gpio_in = 8'h00;
   logic                   alarm_interrupt_line_in = 1'b0;
   logic                   pm_timer_msb_in = 1'b0;
   logic                   global_lock_set_in = 1'b0;
   logic                   acpi_enable_cmd_in = 1'b0;
   logic                   acpi_disable_cmd_in = 1'b0;
   logic                   sci_out, smi_out, smi_event_out;
   logic                   sleep_request_out, wake_out;
   logic [2:0]             sleep_type_out;
   pmev_pkg::pmev_power_t  power_state_out;
   int                     errors = 0;
   int                     n_compared = 0;
   int                     wake_count = 0;
   logic [15:0]            exp_q[$];

   pmev_regs dut (.*);

   always #5 clock_in = ~clock_in;

   task automatic check(string nm, logic [15:0] seen, logic [15:0] exp);
      n_compared++;
      if (seen !== exp) begin
         errors++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic tally_and_finish;
      $display("compared %0d mismatches %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   // Returns just after the edge that takes the request
   task automatic io(logic [7:0] ofs, logic w, logic [15:0] d, logic [15:0] e);
      @(posedge clock_in);
      io_req_in <= '{addr: pmev_pkg::BASE_DEFAULT + 16'(ofs), wr: w, rd: !w,
                     wdata: d};
      exp_q.push_back(e);
      @(posedge clock_in);
      io_req_in <= '0;
   endtask
   task automatic wr(logic [7:0] ofs, logic [15:0] d);
      io(ofs, 1'b1, d, 16'h0000);
   endtask
   task automatic rd(logic [7:0] ofs, logic [15:0] e);
      io(ofs, 1'b0, 16'h0000, e);
      repeat (2) @(posedge clock_in);
   endtask
   // 0 enable command, 1 lock set, 2 disable command
   task automatic strobe(int sel);
      @(posedge clock_in);
      global_lock_set_in  <= sel == 1;
      acpi_enable_cmd_in  <= sel == 0;
      acpi_disable_cmd_in <= sel == 2;
      @(posedge clock_in);
      global_lock_set_in  <= 1'b0;
      acpi_enable_cmd_in  <= 1'b0;
      acpi_disable_cmd_in <= 1'b0;
   endtask
   // Pins cross two synchroniser flops before they count
   task automatic settle;
      repeat (6) @(posedge clock_in);
      #1;
   endtask

   // Every acknowledge carries read data, zero for writes
   always @(posedge clock_in) begin
      if (io_ack_out === 1'b1) begin
         if (exp_q.size() == 0)
            check("spare ack", 16'h0001, 16'h0000);
         else
            check("read data", io_rdata_out, exp_q.pop_front());
      end
      if (wake_out === 1'b1)
         wake_count++;
   end

   initial begin
      #200000;
      errors++;
      tally_and_finish();
   end

   initial begin
      logic [7:0]            ofs_list [7];
      pmev_pkg::pmev_power_t st [8];
      logic [15:0]           r;
      int                    k, kb, kl;
      logic                  ok;
      ofs_list = '{8'h08, 8'h0A, 8'h0C, 8'h0E, 8'h10, 8'h12, 8'h20};
      st = '{pmev_pkg::PMEV_STATE_ON, pmev_pkg::PMEV_STATE_S1,
             pmev_pkg::PMEV_STATE_S2, pmev_pkg::PMEV_STATE_ON,
             pmev_pkg::PMEV_STATE_S4, pmev_pkg::PMEV_STATE_S5,
             pmev_pkg::PMEV_STATE_ON, pmev_pkg::PMEV_STATE_ON};
      r = 16'($urandom(82501));
      k = $urandom % 8;
      kb = (k + 1) % 8;
      kl = (k + 2) % 8;
      repeat (6) @(posedge clock_in);
      rst_in <= 1'b0;
      foreach (ofs_list[i])
         rd(ofs_list[i], 16'h0000);
      $display("test reset values done");

      wr(8'h0A, 16'hFFFF);
      rd(8'h0A, 16'h0721);
      r = 16'($urandom);
      wr(8'h12, r);
      rd(8'h12, r);
      wr(8'h0E, 16'h0013);
      wr(8'h0E, 16'h0005);
      rd(8'h0E, 16'h0013);
      $display("test register access done");

      pm_timer_msb_in <= 1'b1;
      settle();
      check("smi route", 16'(smi_out), 16'h0001);
      check("sci idle", 16'(sci_out), 16'h0000);
      wr(8'h08, 16'h0000);
      rd(8'h08, 16'h0001);
      strobe(0);
      settle();
      check("sci route", 16'(sci_out), 16'h0001);
      rd(8'h0C, 16'h0001);
      wr(8'h08, 16'h0001);
      settle();
      check("sci cleared", 16'(sci_out), 16'h0000);
      $display("test timer and routing done");

      strobe(1);
      rd(8'h08, 16'h0020);
      wr(8'h08, 16'h0020);
      @(posedge clock_in);
      #1;
      check("lock sci", 16'(sci_out), 16'h0001);
      @(posedge clock_in);
      #1;
      check("lock sci end", 16'(sci_out), 16'h0000);
      @(posedge clock_in);
      alarm_interrupt_line_in <= 1'b1;
      settle();
      rd(8'h08, 16'h0000);
      alarm_interrupt_line_in <= 1'b0;
      $display("test global lock done");

      for (int t = 0; t < 8; t++) begin
         ok = !(t inside {3, 6, 7});
         wr(8'h0C, {2'b00, 1'b1, 3'(t), 7'h00, 3'b111});
         #1;
         check("sleep request", 16'(sleep_request_out), 16'(ok));
         check("release event", 16'(smi_event_out), 16'h0001);
         if (ok)
            check("sleep type", 16'(sleep_type_out), 16'(t));
         rd(8'h0C, {3'b000, 3'(t), 10'h001});
         check("power state", 16'(power_state_out), 16'(st[t]));
         if (ok && t != 0) begin
            if (t == 1)
               alarm_interrupt_line_in <= 1'b1;
            else
               pm_timer_msb_in <= ~pm_timer_msb_in;
            settle();
            check("awake", 16'(power_state_out), 16'h0000);
            rd(8'h08, (t == 1) ? 16'h8400 : 16'h8001);
            alarm_interrupt_line_in <= 1'b0;
            wr(8'h08, 16'hFFFF);
         end
      end
      check("wake pulses", 16'(wake_count), 16'h0004);
      $display("test sleep states done");

      gpio_in[k] <= 1'b1;
      settle();
      @(posedge clock_in);
      gpio_in[k] <= 1'b0;
      settle();
      rd(8'h08, 16'h0000);
      wr(8'h0E, 16'h0010 + 16'(k));
      wr(8'h14, 16'h0001);
      wr(8'h0E, 16'h0010 + 16'(kb));
      wr(8'h14, 16'h0002);
      wr(8'h0E, 16'h0010 + 16'(kl));
      wr(8'h14, 16'h0086);
      wr(8'h12, 16'h0040);
      gpio_in <= 8'(1 << k) | 8'(1 << kb) | 8'(1 << kl);
      settle();
      rd(8'h08, 16'h0300);
      rd(8'h10, 16'h0040);
      wr(8'h08, 16'h0300);
      settle();
      check("lid sci", 16'(sci_out), 16'h0001);
      wr(8'h10, 16'h0040);
      settle();
      check("lid sci clear", 16'(sci_out), 16'h0000);
      @(posedge clock_in);
      gpio_in[kl] <= 1'b0;
      settle();
      rd(8'h10, 16'h0040);
      rd(8'h08, 16'h0000);
      strobe(2);
      settle();
      check("smi again", 16'(smi_out), 16'h0001);
      rd(8'h0C, 16'h1C00);
      $display("test pin mapping done");
      tally_and_finish();
   end
endmodule
